// >>> verilog/mmd_defs.svh
/*
  offsets, field positions, reset values and sizes of the indirect
  extended register access path.
  assumes: included by bare name; definitions only.
*/
`ifndef MMD_DEFS_SVH
`define MMD_DEFS_SVH

// ****************************************
// direct register offsets
// ****************************************
`define OFS_MMD_ACCESS_CONTROL 5'h0d
`define OFS_MMD_ADDRESS_DATA 5'h0e

// ****************************************
// control register fields
// ****************************************
`define FUNC_MSB 15
`define FUNC_LSB 14
`define TARGET_DEV_ADDR_MSB 4
`define TARGET_DEV_ADDR_LSB 0
`define DEV_GENERAL 5'h1f

// ****************************************
// reset values, clock config address and clock off bit
// ****************************************
`define CTRL_RESET 16'h0000
`define EXT_ADDR_RESET 16'h0000
`define CLK_CFG_ADDR 16'h0170
`define CLK_CFG_RESET 16'h0c10
`define CLK_OFF_BIT 6

// ****************************************
// sizes, frame counts and opcodes
// ****************************************
`define MEM_AW 10
`define MEM_DEPTH 1024
`define HDR_LAST 4'd11
`define DATA_LAST 4'd15
`define SKIP_LAST 5'd17
`define OP_READ 2'b10
`define OP_WRITE 2'b01

`endif

// >>> verilog/mmd_pkg.sv
/*
  types of the indirect extended register access path.
  assumes: mmd_defs.svh is on the include path.
*/
package mmd_pkg;
`include "mmd_defs.svh"

  typedef enum logic [1:0] {
    FN_ADDR = 2'b00,
    FN_DATA = 2'b01,
    FN_INC_RW = 2'b10,
    FN_INC_WR = 2'b11
  } func_t;

  typedef enum logic [1:0] {
    TGT_MEM = 2'b00,
    TGT_CLK = 2'b01,
    TGT_NONE = 2'b10
  } target_t;

  typedef enum logic [2:0] {
    PS_IDLE = 3'b000,
    PS_START = 3'b001,
    PS_HDR = 3'b010,
    PS_TA = 3'b011,
    PS_RDATA = 3'b100,
    PS_WDATA = 3'b101,
    PS_SKIP = 3'b110
  } port_st_t;

  typedef struct packed {
    port_st_t st;
    logic mdc_prev;
    logic is_read;
    logic [4:0] cnt;
    logic [15:0] sh;
    logic out;
    logic oe;
    logic rd;
    logic wr;
    logic [4:0] reg_addr;
    logic [15:0] wdata;
  } port_state_t;

  typedef struct packed {
    logic [4:0] phy_addr;
    logic [15:0] ctrl;
    logic [15:0] ext_addr;
    logic [15:0] clk_cfg;
    logic rd_mem;
    logic [15:0] rd_local;
  } bank_state_t;
endpackage

// >>> verilog/ext_reg_mem.sv
/*
  single port store of the standard and extended registers.
  assumes: one access per cycle; read data registered, updated only on read.
*/
`timescale 1ns/10ps
`default_nettype none
module ext_reg_mem
  import mmd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic we,
  input wire logic re,
  input wire logic [`MEM_AW-1:0] addr,
  input wire logic [15:0] wdata,
  output logic [15:0] rdata
);
  logic [15:0] mem_q [`MEM_DEPTH];
  logic [15:0] rdata_q;

  // ****************************************
  // storage
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem_q[addr] <= wdata;
    end
    if (re) begin
      rdata_q <= mem_q[addr];
    end
  end

  assign rdata = rdata_q;
endmodule
`default_nettype wire

// >>> verilog/mdio_frame_port.sv
/*
  serial management frame engine: decodes read and write frames.
  assumes: mdc and mdio_in synchronous to clk_sys, mdc at most clk_sys/4;
  rd_data valid two cycles after rd pulse.
*/
`timescale 1ns/10ps
`default_nettype none
module mdio_frame_port
  import mmd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic [4:0] phy_addr,
  output logic rd,
  output logic wr,
  output logic [4:0] reg_addr,
  output logic [15:0] wdata,
  input wire logic [15:0] rd_data
);
  port_state_t s_q, s_d;
  logic rise;
  logic [11:0] hdr;

  // ****************************************
  // frame decode
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.mdc_prev = mdc;
    s_d.rd = 1'b0;
    s_d.wr = 1'b0;
    rise = mdc & ~s_q.mdc_prev;
    hdr = {s_q.sh[10:0], mdio_in};
    if (rise) begin
      unique case (s_q.st)
        PS_IDLE: begin
          if (!mdio_in) begin
            s_d.st = PS_START;
          end
        end
        PS_START: begin
          if (mdio_in) begin
            s_d.st = PS_HDR;
            s_d.cnt = 5'd0;
          end
        end
        PS_HDR: begin
          s_d.sh = {s_q.sh[14:0], mdio_in};
          s_d.cnt = s_q.cnt + 5'd1;
          if (s_q.cnt[3:0] == `HDR_LAST) begin
            s_d.cnt = 5'd0;
            s_d.reg_addr = hdr[4:0];
            s_d.is_read = (hdr[11:10] == `OP_READ);
            if (hdr[9:5] != phy_addr ||
                (hdr[11:10] != `OP_READ && hdr[11:10] != `OP_WRITE)) begin
              s_d.st = PS_SKIP;
            end else begin
              s_d.st = PS_TA;
              s_d.rd = (hdr[11:10] == `OP_READ);
            end
          end
        end
        PS_TA: begin
          s_d.cnt = s_q.cnt + 5'd1;
          if (s_q.cnt == 5'd0) begin
            s_d.oe = s_q.is_read;
            s_d.out = 1'b0;
          end else begin
            s_d.cnt = 5'd0;
            s_d.sh = rd_data;
            s_d.out = rd_data[15];
            s_d.st = s_q.is_read ? PS_RDATA : PS_WDATA;
          end
        end
        PS_RDATA: begin
          s_d.cnt = s_q.cnt + 5'd1;
          s_d.sh = {s_q.sh[14:0], 1'b0};
          s_d.out = s_q.sh[14];
          if (s_q.cnt[3:0] == `DATA_LAST) begin
            s_d.oe = 1'b0;
            s_d.out = 1'b0;
            s_d.st = PS_IDLE;
          end
        end
        PS_WDATA: begin
          s_d.cnt = s_q.cnt + 5'd1;
          s_d.sh = {s_q.sh[14:0], mdio_in};
          if (s_q.cnt[3:0] == `DATA_LAST) begin
            s_d.wdata = {s_q.sh[14:0], mdio_in};
            s_d.wr = 1'b1;
            s_d.st = PS_IDLE;
          end
        end
        PS_SKIP: begin
          s_d.cnt = s_q.cnt + 5'd1;
          if (s_q.cnt == `SKIP_LAST) begin
            s_d.st = PS_IDLE;
          end
        end
        default: begin
          s_d.st = PS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q <= '{st: PS_IDLE, mdc_prev: 1'b0, is_read: 1'b0, cnt: 5'd0, sh: 16'h0000,
               out: 1'b0, oe: 1'b0, rd: 1'b0, wr: 1'b0, reg_addr: 5'h00,
               wdata: 16'h0000};
    end else begin
      s_q <= s_d;
    end
  end

  assign mdio_out = s_q.out;
  assign mdio_oe = s_q.oe;
  assign rd = s_q.rd;
  assign wr = s_q.wr;
  assign reg_addr = s_q.reg_addr;
  assign wdata = s_q.wdata;
endmodule
`default_nettype wire

// >>> verilog/mmd_indirect_register_access.sv
/*
  management register bank with indirect access to the extended space.
  assumes: station controller drives mdc/mdio synchronous to clk_sys, mdc
  at most clk_sys/4; phy_addr_strap steady while rst is high.
*/
`timescale 1ns/10ps
`default_nettype none
module mmd_indirect_register_access
  import mmd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  input wire logic [4:0] phy_addr_strap,
  output logic clk_out_en
);
  bank_state_t s_q, s_d;
  logic acc_rd, acc_wr;
  logic [4:0] acc_reg;
  logic [15:0] acc_wdata, rd_data, mem_rdata, mem_wdata;
  logic mem_we, mem_re, dev_ok;
  logic [`MEM_AW-1:0] mem_addr;
  func_t func;
  target_t tgt;

  // ****************************************
  // extended address decode
  // ****************************************
  function automatic target_t target_of(input logic [15:0] a);
    if (a == {11'h000, `OFS_MMD_ACCESS_CONTROL} ||
        a == {11'h000, `OFS_MMD_ADDRESS_DATA}) begin
      target_of = TGT_NONE;
    end else if (a == `CLK_CFG_ADDR) begin
      target_of = TGT_CLK;
    end else if (a < `MEM_DEPTH) begin
      target_of = TGT_MEM;
    end else begin
      target_of = TGT_NONE;
    end
  endfunction

  mdio_frame_port u_port (
    .clk_sys(clk_sys),
    .rst(rst),
    .mdc(mdc),
    .mdio_in(mdio_in),
    .mdio_out(mdio_out),
    .mdio_oe(mdio_oe),
    .phy_addr(s_q.phy_addr),
    .rd(acc_rd),
    .wr(acc_wr),
    .reg_addr(acc_reg),
    .wdata(acc_wdata),
    .rd_data(rd_data)
  );

  ext_reg_mem u_mem (
    .clk_sys(clk_sys),
    .we(mem_we),
    .re(mem_re),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  // ****************************************
  // access handling
  // ****************************************
  always_comb begin
    s_d = s_q;
    func = func_t'(s_q.ctrl[`FUNC_MSB:`FUNC_LSB]);
    dev_ok = (s_q.ctrl[`TARGET_DEV_ADDR_MSB:`TARGET_DEV_ADDR_LSB] == `DEV_GENERAL);
    tgt = target_of(s_q.ext_addr);
    mem_we = 1'b0;
    mem_re = 1'b0;
    mem_addr = {5'h00, acc_reg};
    mem_wdata = acc_wdata;
    if (acc_wr) begin
      if (acc_reg == `OFS_MMD_ACCESS_CONTROL) begin
        s_d.ctrl = acc_wdata;
      end else if (acc_reg == `OFS_MMD_ADDRESS_DATA) begin
        if (dev_ok) begin
          if (func == FN_ADDR) begin
            s_d.ext_addr = acc_wdata;
          end else begin
            mem_addr = s_q.ext_addr[`MEM_AW-1:0];
            if (tgt == TGT_CLK) begin
              s_d.clk_cfg = acc_wdata;
            end
            mem_we = (tgt == TGT_MEM);
            if (func != FN_DATA) begin
              s_d.ext_addr = s_q.ext_addr + 16'h0001;
            end
          end
        end
      end else begin
        mem_we = 1'b1;
      end
    end
    if (acc_rd) begin
      s_d.rd_mem = 1'b0;
      s_d.rd_local = 16'h0000;
      if (acc_reg == `OFS_MMD_ACCESS_CONTROL) begin
        s_d.rd_local = s_q.ctrl;
      end else if (acc_reg == `OFS_MMD_ADDRESS_DATA) begin
        if (dev_ok) begin
          if (func == FN_ADDR) begin
            s_d.rd_local = s_q.ext_addr;
          end else begin
            mem_addr = s_q.ext_addr[`MEM_AW-1:0];
            if (tgt == TGT_CLK) begin
              s_d.rd_local = s_q.clk_cfg;
            end
            s_d.rd_mem = (tgt == TGT_MEM);
            mem_re = (tgt == TGT_MEM);
            if (func == FN_INC_RW) begin
              s_d.ext_addr = s_q.ext_addr + 16'h0001;
            end
          end
        end
      end else begin
        s_d.rd_mem = 1'b1;
        mem_re = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q <= '{phy_addr: phy_addr_strap, ctrl: `CTRL_RESET, ext_addr: `EXT_ADDR_RESET,
               clk_cfg: `CLK_CFG_RESET, rd_mem: 1'b0, rd_local: 16'h0000};
    end else begin
      s_q <= s_d;
    end
  end

  assign rd_data = s_q.rd_mem ? mem_rdata : s_q.rd_local;
  assign clk_out_en = ~s_q.clk_cfg[`CLK_OFF_BIT];

  // ****************************************
  // checks
  // ****************************************
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  logic data_acc;
  assign data_acc = (acc_rd | acc_wr) && acc_reg == `OFS_MMD_ADDRESS_DATA;

  property p_bad_dev;
    data_acc && !dev_ok |=> $stable(s_q.ext_addr) && $stable(s_q.clk_cfg);
  endproperty
  a_bad_dev: assert property (p_bad_dev) else $error("access under wrong device changed state");

  property p_addr_load;
    acc_wr && acc_reg == `OFS_MMD_ADDRESS_DATA && dev_ok && func == FN_ADDR
      |=> s_q.ext_addr == $past(acc_wdata);
  endproperty
  a_addr_load: assert property (p_addr_load) else $error("address function did not load address");

  property p_no_inc;
    data_acc && dev_ok && func == FN_DATA |=> $stable(s_q.ext_addr);
  endproperty
  a_no_inc: assert property (p_no_inc) else $error("data function moved the address");

  property p_inc_rw;
    data_acc && dev_ok && func == FN_INC_RW |=> s_q.ext_addr == $past(s_q.ext_addr) + 16'h0001;
  endproperty
  a_inc_rw: assert property (p_inc_rw) else $error("increment on access missing");

  property p_inc_wr;
    data_acc && dev_ok && func == FN_INC_WR
      |=> s_q.ext_addr == $past(s_q.ext_addr) + {15'h0000, $past(acc_wr)};
  endproperty
  a_inc_wr: assert property (p_inc_wr) else $error("write-only increment wrong");

  property p_clk_off;
    acc_wr && acc_reg == `OFS_MMD_ADDRESS_DATA && dev_ok && func != FN_ADDR &&
      s_q.ext_addr == `CLK_CFG_ADDR && acc_wdata == 16'h0c50 |=> !clk_out_en ##1 !clk_out_en;
  endproperty
  a_clk_off: assert property (p_clk_off) else $error("clock output not switched off");

  property p_self_blocked;
    data_acc && dev_ok && func != FN_ADDR && tgt == TGT_NONE |-> !mem_we && !mem_re;
  endproperty
  a_self_blocked: assert property (p_self_blocked) else $error("indirect reached blocked register");

  property p_direct;
    acc_wr && acc_reg != `OFS_MMD_ACCESS_CONTROL && acc_reg != `OFS_MMD_ADDRESS_DATA
      |-> mem_we && mem_addr == {5'h00, acc_reg};
  endproperty
  a_direct: assert property (p_direct) else $error("direct write missed its register");

  property p_read_data;
    acc_rd && acc_reg == `OFS_MMD_ACCESS_CONTROL |=> ##1 rd_data == $past(s_q.ctrl, 2);
  endproperty
  a_read_data: assert property (p_read_data) else $error("control read returned wrong value");

  property p_ctrl_wr;
    acc_wr && acc_reg == `OFS_MMD_ACCESS_CONTROL |=> s_q.ctrl == $past(acc_wdata);
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write lost");

  property p_ctrl_kept;
    data_acc |=> $stable(s_q.ctrl);
  endproperty
  a_ctrl_kept: assert property (p_ctrl_kept) else $error("control changed");

  property p_ext_wr;
    acc_wr && acc_reg == `OFS_MMD_ADDRESS_DATA && dev_ok && func != FN_ADDR && tgt == TGT_MEM
      |-> mem_we && mem_addr == s_q.ext_addr[`MEM_AW-1:0] && mem_wdata == acc_wdata;
  endproperty
  a_ext_wr: assert property (p_ext_wr) else $error("indirect write missed");

  property p_ext_rd;
    acc_rd && acc_reg == `OFS_MMD_ADDRESS_DATA && dev_ok && func != FN_ADDR && tgt == TGT_MEM
      |-> mem_re && mem_addr == s_q.ext_addr[`MEM_AW-1:0];
  endproperty
  a_ext_rd: assert property (p_ext_rd) else $error("indirect read missed");

  property p_addr_rd;
    acc_rd && acc_reg == `OFS_MMD_ADDRESS_DATA && dev_ok && func == FN_ADDR
      |=> ##1 rd_data == $past(s_q.ext_addr, 2);
  endproperty
  a_addr_rd: assert property (p_addr_rd) else $error("address read wrong");

  property p_bad_dev_rd;
    acc_rd && acc_reg == `OFS_MMD_ADDRESS_DATA && !dev_ok |=> ##1 rd_data == 16'h0000;
  endproperty
  a_bad_dev_rd: assert property (p_bad_dev_rd) else $error("wrong device read");

  property p_bad_dev_mem;
    data_acc && !dev_ok |-> !mem_we && !mem_re;
  endproperty
  a_bad_dev_mem: assert property (p_bad_dev_mem) else $error("wrong device access");

  property p_direct_rd;
    acc_rd && acc_reg != `OFS_MMD_ACCESS_CONTROL && acc_reg != `OFS_MMD_ADDRESS_DATA
      |-> mem_re && mem_addr == {5'h00, acc_reg};
  endproperty
  a_direct_rd: assert property (p_direct_rd) else $error("direct read missed");

  property p_inc_wr_rd;
    acc_rd && acc_reg == `OFS_MMD_ADDRESS_DATA && dev_ok && func == FN_INC_WR
      |=> $stable(s_q.ext_addr);
  endproperty
  a_inc_wr_rd: assert property (p_inc_wr_rd) else $error("read moved address");

  property p_clk_wr;
    acc_wr && acc_reg == `OFS_MMD_ADDRESS_DATA && dev_ok && func != FN_ADDR &&
      tgt == TGT_CLK |=> s_q.clk_cfg == $past(acc_wdata);
  endproperty
  a_clk_wr: assert property (p_clk_wr) else $error("clock config write lost");

  property p_clk_rd;
    acc_rd && acc_reg == `OFS_MMD_ADDRESS_DATA && dev_ok && func != FN_ADDR &&
      tgt == TGT_CLK |=> ##1 rd_data == $past(s_q.clk_cfg, 2);
  endproperty
  a_clk_rd: assert property (p_clk_rd) else $error("clock config read wrong");

  property p_clk_hold;
    !(acc_wr && acc_reg == `OFS_MMD_ADDRESS_DATA && dev_ok && func != FN_ADDR &&
      tgt == TGT_CLK) |=> $stable(clk_out_en);
  endproperty
  a_clk_hold: assert property (p_clk_hold) else $error("clock enable moved");

  property p_addr_hold;
    !data_acc |=> $stable(s_q.ext_addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved");

  property p_addr_fn_mem;
    data_acc && dev_ok && func == FN_ADDR |-> !mem_we && !mem_re;
  endproperty
  a_addr_fn_mem: assert property (p_addr_fn_mem) else $error("address access hit store");

  property p_phy_hold;
    1'b1 |=> $stable(s_q.phy_addr);
  endproperty
  a_phy_hold: assert property (p_phy_hold) else $error("management address moved");

  property p_ctrl_no_mem;
    acc_wr && acc_reg == `OFS_MMD_ACCESS_CONTROL |-> !mem_we;
  endproperty
  a_ctrl_no_mem: assert property (p_ctrl_no_mem) else $error("control write hit store");
endmodule
`default_nettype wire

// >>> verif/mdio_station_model.sv
/*
  station management controller model: issues clause-22 frames on mdc/mdio.
  assumes: mdio wire resolved outside (pull-up when nobody drives);
  mdc kept at clk_sys/4 and held low between frames.
*/
`timescale 1ns/10ps
`default_nettype none
module mdio_station_model
  import mmd_pkg::*;
#(
  parameter logic [4:0] PHY = 5'h05
)
(
  input wire logic clk_sys,
  output logic mdc,
  output logic sta_out,
  output logic sta_oe,
  input wire logic mdio_wire
);
`include "mmd_defs.svh"
  logic [4:0] phy_sel;

  initial begin
    mdc = 1'b0;
    sta_out = 1'b1;
    sta_oe = 1'b0;
    phy_sel = PHY;
  end

  // ****************************************
  // bit and frame level
  // ****************************************
  task automatic bit_cyc(input logic b, input logic drv, output logic smp);
    @(posedge clk_sys);
    mdc <= 1'b0;
    sta_out <= b;
    sta_oe <= drv;
    repeat (2) @(posedge clk_sys);
    smp = mdio_wire;
    mdc <= 1'b1;
    @(posedge clk_sys);
  endtask

  task automatic frame(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
                       output logic [15:0] rd);
    logic [16:0] seq;
    logic s;
    logic rd_op;
    rd_op = (op == `OP_READ);
    seq = {1'b1, 2'b01, op, phy_sel, ra, 2'b10};
    for (int i = 16; i >= 0; i--) begin
      bit_cyc(seq[i], (i != 16) && (i > 1 || !rd_op), s);
    end
    for (int i = 15; i >= 0; i--) begin
      bit_cyc(wd[i], !rd_op, s);
      rd[i] = s;
    end
    @(posedge clk_sys);
    mdc <= 1'b0;
    sta_oe <= 1'b0;
    @(posedge clk_sys);
  endtask

  // ****************************************
  // register level
  // ****************************************
  task automatic wr_reg(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] x;
    frame(`OP_WRITE, ra, d, x);
  endtask

  task automatic rd_reg(input logic [4:0] ra, output logic [15:0] d);
    frame(`OP_READ, ra, 16'h0000, d);
  endtask

  task automatic set_fn(input logic [1:0] f);
    wr_reg(`OFS_MMD_ACCESS_CONTROL, {f, 9'h000, `DEV_GENERAL});
  endtask

  task automatic set_addr(input logic [15:0] a);
    set_fn(2'b00);
    wr_reg(`OFS_MMD_ADDRESS_DATA, a);
  endtask

  task automatic ext_wr(input logic [15:0] a, input logic [15:0] d);
    set_addr(a);
    set_fn(2'b01);
    wr_reg(`OFS_MMD_ADDRESS_DATA, d);
  endtask

  task automatic ext_rd(input logic [15:0] a, output logic [15:0] d);
    set_addr(a);
    set_fn(2'b01);
    rd_reg(`OFS_MMD_ADDRESS_DATA, d);
  endtask
endmodule
`default_nettype wire

// >>> verif/mmd_indirect_register_access_tb.sv
/*
  self-checking testbench of the indirect extended register access path.
  assumes: station model drives the link; pull-up on the mdio wire.
*/
`timescale 1ns/10ps
`default_nettype none
module mmd_indirect_register_access_tb;
`include "mmd_defs.svh"
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic mdc;
  logic sta_out;
  logic sta_oe;
  logic mdio_out;
  logic mdio_oe;
  logic clk_out_en;
  logic [4:0] strap = 5'h05;
  wire logic mdio_wire = mdio_oe ? mdio_out : (sta_oe ? sta_out : 1'b1);
  int mismatches = 0;
  int cmp_count = 0;
  localparam logic [4:0] CTL = `OFS_MMD_ACCESS_CONTROL;
  localparam logic [4:0] DAT = `OFS_MMD_ADDRESS_DATA;

  always #25 clk_sys = ~clk_sys;

  mmd_indirect_register_access DUT (
    .clk_sys(clk_sys), .rst(rst), .mdc(mdc), .mdio_in(mdio_wire),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .phy_addr_strap(strap),
    .clk_out_en(clk_out_en)
  );

  mdio_station_model #(.PHY(5'h05)) u_sta (
    .clk_sys(clk_sys), .mdc(mdc), .sta_out(sta_out), .sta_oe(sta_oe), .mdio_wire(mdio_wire)
  );

  // ****************************************
  // compare and closing
  // ****************************************
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_direct;
    logic [15:0] d;
    u_sta.wr_reg(5'd3, 16'ha5c3);
    u_sta.wr_reg(5'd31, 16'h1234);
    u_sta.rd_reg(5'd3, d);
    chk16(d, 16'ha5c3);
    u_sta.rd_reg(5'd31, d);
    chk16(d, 16'h1234);
    u_sta.phy_sel = 5'h06;
    u_sta.wr_reg(5'd3, 16'h0000);
    u_sta.phy_sel = 5'h05;
    u_sta.rd_reg(5'd3, d);
    chk16(d, 16'ha5c3);
    u_sta.rd_reg(CTL, d);
    chk16(d, `CTRL_RESET);
    u_sta.rd_reg(DAT, d);
    chk16(d, 16'h0000);
  endtask

  task automatic t_clk;
    logic [15:0] d;
    u_sta.ext_rd(`CLK_CFG_ADDR, d);
    chk16(d, `CLK_CFG_RESET);
    chk1(clk_out_en, 1'b1);
    u_sta.ext_wr(`CLK_CFG_ADDR, 16'h0c50);
    chk1(clk_out_en, 1'b0);
    u_sta.ext_wr(`CLK_CFG_ADDR, 16'h0c10);
    chk1(clk_out_en, 1'b1);
  endtask

  task automatic t_fixed;
    logic [15:0] d;
    u_sta.set_addr(16'h0123);
    u_sta.wr_reg(DAT, 16'h0155);
    u_sta.rd_reg(DAT, d);
    chk16(d, 16'h0155);
    u_sta.set_fn(2'b01);
    u_sta.wr_reg(DAT, 16'hbeef);
    u_sta.wr_reg(DAT, 16'hcafe);
    u_sta.rd_reg(DAT, d);
    chk16(d, 16'hcafe);
    u_sta.rd_reg(DAT, d);
    chk16(d, 16'hcafe);
    u_sta.set_fn(2'b00);
    u_sta.rd_reg(DAT, d);
    chk16(d, 16'h0155);
    u_sta.set_fn(2'b01);
    u_sta.rd_reg(DAT, d);
    chk16(d, 16'hcafe);
  endtask

  task automatic t_inc_rw;
    logic [15:0] d;
    u_sta.set_addr(16'h0200);
    u_sta.set_fn(2'b10);
    for (int i = 0; i < 4; i++) begin
      u_sta.wr_reg(DAT, 16'h1000 + 16'(i));
    end
    u_sta.set_fn(2'b00);
    u_sta.rd_reg(DAT, d);
    chk16(d, 16'h0204);
    u_sta.set_addr(16'h0200);
    u_sta.set_fn(2'b10);
    for (int i = 0; i < 4; i++) begin
      u_sta.rd_reg(DAT, d);
      chk16(d, 16'h1000 + 16'(i));
    end
    u_sta.set_fn(2'b00);
    u_sta.rd_reg(DAT, d);
    chk16(d, 16'h0204);
  endtask

  task automatic t_inc_wr;
    logic [15:0] d;
    u_sta.set_addr(16'h0300);
    u_sta.set_fn(2'b11);
    u_sta.wr_reg(DAT, 16'haaaa);
    u_sta.wr_reg(DAT, 16'h5555);
    u_sta.set_fn(2'b00);
    u_sta.rd_reg(DAT, d);
    chk16(d, 16'h0302);
    u_sta.wr_reg(DAT, 16'h0300);
    u_sta.set_fn(2'b11);
    u_sta.rd_reg(DAT, d);
    u_sta.rd_reg(DAT, d);
    chk16(d, 16'haaaa);
    u_sta.set_fn(2'b00);
    u_sta.rd_reg(DAT, d);
    chk16(d, 16'h0300);
  endtask

  task automatic t_alias;
    logic [15:0] d;
    u_sta.ext_wr(16'h0003, 16'h0f0f);
    u_sta.rd_reg(5'd3, d);
    chk16(d, 16'h0f0f);
    u_sta.ext_wr(16'h000d, 16'hffff);
    u_sta.rd_reg(CTL, d);
    chk16(d, 16'h401f);
    u_sta.ext_rd(16'h000e, d);
    chk16(d, 16'h0000);
  endtask

  task automatic t_dev;
    logic [15:0] d;
    u_sta.ext_wr(16'h0040, 16'h1111);
    u_sta.wr_reg(CTL, 16'h401e);
    u_sta.wr_reg(DAT, 16'h2222);
    u_sta.rd_reg(DAT, d);
    chk16(d, 16'h0000);
    u_sta.wr_reg(CTL, 16'h001e);
    u_sta.wr_reg(DAT, 16'h0050);
    u_sta.set_fn(2'b00);
    u_sta.rd_reg(DAT, d);
    chk16(d, 16'h0040);
    u_sta.set_fn(2'b01);
    u_sta.rd_reg(DAT, d);
    chk16(d, 16'h1111);
  endtask

  task automatic t_strap;
    logic [15:0] d;
    u_sta.ext_wr(`CLK_CFG_ADDR, 16'h0c50);
    chk1(clk_out_en, 1'b0);
    strap <= 5'h0a;
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk1(clk_out_en, 1'b1);
    chk1(mdio_oe, 1'b0);
    u_sta.wr_reg(5'd3, 16'h0000);
    u_sta.phy_sel = 5'h0a;
    u_sta.rd_reg(5'd3, d);
    chk16(d, 16'h0f0f);
    u_sta.rd_reg(CTL, d);
    chk16(d, `CTRL_RESET);
  endtask

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    t_direct();
    t_clk();
    t_fixed();
    t_inc_rw();
    t_inc_wr();
    t_alias();
    t_dev();
    t_strap();
    stop_test();
  end

  initial begin
    repeat (60000) @(posedge clk_sys);
    mismatches++;
    stop_test();
  end
endmodule
`default_nettype wire
